/* scan_prog_pkg.sv */
// constants and types for the scan-port flash programmer
//
// Overview of operation
// - fuse write: 0 programs, 1 unprograms
// - lock write: 0 programs, 1 keeps bit
// - hold clock, brownout, boot, keep, port, debug fuses
// - page-load chain is 1024 bits long
// - 8-bit shifter moves each byte to buffer
// - page-read chain is 1032 bits long
// - first eight read bits are filler
// - read chain outputs word 0 LSB first
// - only the 16-bit key enables programming
// - completion flag reports erase done
// - page write then poll completion flag
// - low six address bits index page words
package scan_prog_pkg;

  // ****************************************************************
  // scan instructions and chain lengths
  // ****************************************************************
  localparam logic [3:0] IR_CORE_HOLD = 4'hc;
  localparam logic [3:0] IR_UNLOCK = 4'h4;
  localparam logic [3:0] IR_CMD = 4'h5;
  localparam logic [3:0] IR_PAGE_FILL = 4'h6;
  localparam logic [3:0] IR_PAGE_DUMP = 4'h7;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [15:0] UNLOCK_KEY = 16'ha370;
  localparam logic [10:0] PAGE_BITS = 11'h400;
  localparam logic [6:0] PAGE_LAST_BYTE = 7'h7f;

  // ****************************************************************
  // command codes and mode bytes
  // ****************************************************************
  localparam logic [6:0] CMD_MODE = 7'h23;
  localparam logic [6:0] CMD_ADDR_HI = 7'h07;
  localparam logic [6:0] CMD_ADDR_LO = 7'h03;
  localparam logic [6:0] CMD_DATA_LO = 7'h13;
  localparam logic [6:0] CMD_DATA_HI = 7'h17;
  localparam logic [6:0] CMD_LATCH = 7'h77;
  localparam logic [6:0] CMD_STROBE_A = 7'h31;
  localparam logic [6:0] CMD_STROBE_B = 7'h35;
  localparam logic [6:0] CMD_RD_A = 7'h32;
  localparam logic [6:0] CMD_RD_B = 7'h36;
  localparam logic [6:0] CMD_RD_FUSE_HI = 7'h3e;
  localparam logic [7:0] MODE_NOP = 8'h00;
  localparam logic [7:0] MODE_ERASE = 8'h80;
  localparam logic [7:0] MODE_FLASH_WR = 8'h10;
  localparam logic [7:0] MODE_FLASH_RD = 8'h02;
  localparam logic [7:0] MODE_FUSE_WR = 8'h40;
  localparam logic [7:0] MODE_LOCK_WR = 8'h20;
  localparam logic [7:0] MODE_FUSE_RD = 8'h04;
  localparam int DONE_BIT = 9;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int ERASE_WAIT_TIME_NS = 2000000;
  localparam int PAGE_WRITE_WAIT_TIME_NS = 1000000;
  localparam int ERASE_CYCLES =
    (ERASE_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_WRITE_CYCLES =
    (PAGE_WRITE_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // register map and reset values
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_CMDSTATE = 8'h0c;
  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3, TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5,
    TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he,
    TAP_UPD_IR = 4'hf
  } tap_t;

  typedef struct packed {
    logic brownout_level_fuse;
    logic brownout_enable_fuse;
    logic [1:0] spareLo;
    logic clock_select_fuse3;
    logic clock_select_fuse2;
    logic clock_select_fuse1;
    logic clock_select_fuse0;
  } fuse_lo_t;

  typedef struct packed {
    logic debug_enable_fuse;
    logic scan_port_enable_fuse;
    logic [1:0] spareHi;
    logic eeprom_keep_fuse;
    logic boot_size_fuse1;
    logic boot_size_fuse0;
    logic boot_vector_fuse;
  } fuse_hi_t;

  typedef struct packed {
    logic [1:0] spareLock;
    logic bootLock12;
    logic bootLock11;
    logic bootLock02;
    logic bootLock01;
    logic memLock2;
    logic memLock1;
  } lock_t;

  typedef struct packed {
    fuse_lo_t fuseLo;
    fuse_hi_t fuseHi;
    lock_t lock;
  } config_t;

  typedef struct packed {
    logic write;
    logic [5:0] wordIdx;
    logic [15:0] data;
    logic [1:0] byteEn;
  } buf_wr_t;

  typedef struct packed {
    logic req;
    logic [14:0] addr;
  } flash_rd_t;

endpackage : scan_prog_pkg

/* scan_port_flash_programmer.sv */
// scan-port flash programmer: test port, command decode, apb registers
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module scan_port_flash_programmer import scan_prog_pkg::*; #(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PAGE_WRITE_CNT = PAGE_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOeN,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic coreHold,
  output logic progEnabled,
  output config_t configBits,
  output buf_wr_t bufWrite,
  output flash_rd_t flashRead,
  input wire logic [7:0] flashRdData,
  output logic eraseStrobe,
  output logic pageWrite,
  output logic [7:0] pageAddr
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic tckS1;
    logic tckS2;
    logic tckPrev;
    logic tmsS1;
    logic tmsS2;
    logic tdiS1;
    logic tdiS2;
    tap_t tap;
    logic [3:0] ir;
    logic [3:0] irSh;
    logic [15:0] dr;
    logic [10:0] bitCnt;
    logic coreHold;
    logic progEn;
    logic [7:0] mode;
    logic [15:0] addr;
    logic [7:0] dataLo;
    logic [7:0] dataHi;
    logic [7:0] readByte;
    logic [7:0] fetched;
    logic rdPend;
    logic rdToCmd;
    config_t cfg;
    logic [14:0] busyCnt;
    logic tdo;
    logic tdoOeN;
    logic linkEnable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    buf_wr_t bufW;
    flash_rd_t rd;
    logic eraseStrobe;
    logic pageWrite;
    logic [7:0] pageAddr;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic tap_t tapStep(tap_t t, logic m);
    unique case (t)
      TAP_RESET: tapStep = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tapStep = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tapStep = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tapStep = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tapStep = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tapStep = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tapStep = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tapStep = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tapStep = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tapStep = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tapStep = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tapStep = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tapStep = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tapStep = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tapStep = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tapStep = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction : tapStep

  // top bit index of the selected chain, one less than its length; the new bit enters there
  function automatic logic [3:0] chainTop(logic [3:0] i);
    unique case (i)
      IR_UNLOCK: chainTop = 4'hf;
      IR_CMD: chainTop = 4'he;
      IR_PAGE_FILL: chainTop = 4'h7;
      IR_PAGE_DUMP: chainTop = 4'h7;
      default: chainTop = 4'h0;
    endcase
  endfunction : chainTop

  logic rise;
  logic fall;
  logic busy;
  logic [6:0] cmdCode;
  logic [7:0] cmdData;
  logic [6:0] byteIdx;
  logic [7:0] apbAddr;

  assign rise = s_reg.tckS2 & ~s_reg.tckPrev;
  assign fall = ~s_reg.tckS2 & s_reg.tckPrev;
  assign busy = s_reg.busyCnt != 15'h0;
  assign cmdCode = s_reg.dr[14:8];
  assign cmdData = s_reg.dr[7:0];
  assign byteIdx = s_reg.bitCnt[9:3];
  assign apbAddr = paddr[7:0];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.tckS1 = tck;
    s_next.tckS2 = s_reg.tckS1;
    s_next.tckPrev = s_reg.tckS2;
    s_next.tmsS1 = tms;
    s_next.tmsS2 = s_reg.tmsS1;
    s_next.tdiS1 = tdi;
    s_next.tdiS2 = s_reg.tdiS1;
    s_next.bufW.write = 1'b0;
    s_next.rd.req = 1'b0;
    s_next.eraseStrobe = 1'b0;
    s_next.pageWrite = 1'b0;
    if (busy) begin
      s_next.busyCnt = s_reg.busyCnt - 15'h1;
    end

    // flash read data arrives one cycle after the request
    s_next.rdPend = s_reg.rd.req;
    if (s_reg.rdPend) begin
      if (s_reg.rdToCmd) begin
        s_next.readByte = flashRdData;
      end else begin
        s_next.fetched = flashRdData;
      end
    end

    if (!s_reg.linkEnable) begin
      s_next.tap = TAP_RESET;
      s_next.ir = IR_BYPASS;
      s_next.tdoOeN = 1'b1;
    end else if (rise) begin
      s_next.tap = tapStep(s_reg.tap, s_reg.tmsS2);
      unique case (s_reg.tap)
        TAP_RESET: begin
          s_next.ir = IR_BYPASS;
        end
        TAP_CAP_IR: begin
          s_next.irSh = IR_CAPTURE;
        end
        TAP_SH_IR: begin
          s_next.irSh = {s_reg.tdiS2, s_reg.irSh[3:1]};
        end
        TAP_UPD_IR: begin
          s_next.ir = s_reg.irSh;
        end
        TAP_CAP_DR: begin
          s_next.bitCnt = 11'h0;
          s_next.dr = 16'h0;
          unique case (s_reg.ir)
            IR_CORE_HOLD: s_next.dr[0] = s_reg.coreHold;
            IR_CMD: begin
              s_next.dr[DONE_BIT] = ~busy;
              s_next.dr[7:0] = s_reg.readByte;
            end
            IR_PAGE_DUMP: begin
              // prefetch byte 0 while the filler bits go out
              s_next.rd.req = s_reg.progEn;
              s_next.rd.addr = {s_reg.addr[13:6], 7'h0};
              s_next.rdToCmd = 1'b0;
            end
            default: ;
          endcase
        end
        TAP_SH_DR: begin
          s_next.dr = s_reg.dr >> 1;
          s_next.dr[chainTop(s_reg.ir)] = s_reg.tdiS2;
          if (s_reg.bitCnt != 11'h7ff) begin
            s_next.bitCnt = s_reg.bitCnt + 11'h1;
          end
          if (s_reg.ir == IR_PAGE_FILL && s_reg.progEn &&
              s_reg.bitCnt < PAGE_BITS && s_reg.bitCnt[2:0] == 3'h7) begin
            s_next.bufW.write = 1'b1;
            s_next.bufW.wordIdx = s_reg.bitCnt[9:4];
            s_next.bufW.byteEn = {s_reg.bitCnt[3], ~s_reg.bitCnt[3]};
            s_next.bufW.data = {s_reg.tdiS2, s_reg.dr[7:1],
                                s_reg.tdiS2, s_reg.dr[7:1]};
          end
          if (s_reg.ir == IR_PAGE_DUMP && s_reg.progEn &&
              s_reg.bitCnt < PAGE_BITS && s_reg.bitCnt[2:0] == 3'h7) begin
            s_next.dr[7:0] = s_reg.fetched;
            if (byteIdx != PAGE_LAST_BYTE) begin
              s_next.rd.req = 1'b1;
              s_next.rd.addr = {s_reg.addr[13:6], byteIdx + 7'h1};
              s_next.rdToCmd = 1'b0;
            end
          end
        end
        TAP_UPD_DR: begin
          unique case (s_reg.ir)
            IR_CORE_HOLD: s_next.coreHold = s_reg.dr[0];
            IR_UNLOCK: begin
              s_next.progEn = s_reg.dr == UNLOCK_KEY;
              if (s_reg.dr != UNLOCK_KEY) begin
                s_next.mode = MODE_NOP;
              end
            end
            IR_CMD: begin
              if (s_reg.progEn) begin
                unique case (cmdCode)
                  CMD_MODE: s_next.mode = cmdData;
                  CMD_ADDR_HI: s_next.addr[15:8] = cmdData;
                  CMD_ADDR_LO: s_next.addr[7:0] = cmdData;
                  CMD_DATA_LO: s_next.dataLo = cmdData;
                  CMD_DATA_HI: s_next.dataHi = cmdData;
                  CMD_LATCH: begin
                    if (s_reg.mode == MODE_FLASH_WR) begin
                      s_next.bufW.write = 1'b1;
                      s_next.bufW.wordIdx = s_reg.addr[5:0];
                      s_next.bufW.byteEn = 2'h3;
                      s_next.bufW.data = {s_reg.dataHi, s_reg.dataLo};
                    end
                  end
                  CMD_STROBE_A: begin
                    if (s_reg.mode == MODE_ERASE && !busy) begin
                      s_next.eraseStrobe = 1'b1;
                      s_next.busyCnt = 15'(ERASE_CNT);
                      s_next.cfg.lock = lock_t'(LOCK_RST);
                    end else if (s_reg.mode == MODE_FUSE_WR) begin
                      s_next.cfg.fuseLo = fuse_lo_t'(s_reg.dataLo);
                    end else if (s_reg.mode == MODE_LOCK_WR) begin
                      s_next.cfg.lock =
                        s_reg.cfg.lock & lock_t'(s_reg.dataLo);
                    end
                  end
                  CMD_STROBE_B: begin
                    if (s_reg.mode == MODE_FLASH_WR && !busy) begin
                      s_next.pageWrite = 1'b1;
                      s_next.pageAddr = s_reg.addr[13:6];
                      s_next.busyCnt = 15'(PAGE_WRITE_CNT);
                    end else if (s_reg.mode == MODE_FUSE_WR) begin
                      s_next.cfg.fuseHi = fuse_hi_t'(s_reg.dataLo);
                    end
                  end
                  CMD_RD_A: begin
                    if (s_reg.mode == MODE_FLASH_RD) begin
                      s_next.rd.req = 1'b1;
                      s_next.rd.addr = {s_reg.addr[13:0], 1'b0};
                      s_next.rdToCmd = 1'b1;
                    end else if (s_reg.mode == MODE_FUSE_RD) begin
                      s_next.readByte = s_reg.cfg.fuseLo;
                    end
                  end
                  CMD_RD_B: begin
                    if (s_reg.mode == MODE_FLASH_RD) begin
                      s_next.rd.req = 1'b1;
                      s_next.rd.addr = {s_reg.addr[13:0], 1'b1};
                      s_next.rdToCmd = 1'b1;
                    end else if (s_reg.mode == MODE_FUSE_RD) begin
                      s_next.readByte = s_reg.cfg.lock;
                    end
                  end
                  CMD_RD_FUSE_HI: begin
                    if (s_reg.mode == MODE_FUSE_RD) begin
                      s_next.readByte = s_reg.cfg.fuseHi;
                    end
                  end
                  default: ;
                endcase
              end
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end else if (fall) begin
      // data out changes on the falling test clock edge
      s_next.tdoOeN = 1'b1;
      if (s_reg.tap == TAP_SH_IR) begin
        s_next.tdo = s_reg.irSh[0];
        s_next.tdoOeN = 1'b0;
      end else if (s_reg.tap == TAP_SH_DR) begin
        s_next.tdo = s_reg.dr[0];
        s_next.tdoOeN = 1'b0;
      end
    end

    // apb: one wait state, write takes effect with pready high
    s_next.pready = psel & penable & ~s_reg.pready;
    if (psel && penable && !s_reg.pready) begin
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h0;
      unique case (apbAddr)
        ADDR_CTRL: s_next.prdata[0] = s_reg.linkEnable;
        ADDR_STATUS: s_next.prdata[2:0] = {busy, s_reg.coreHold,
                                           s_reg.progEn};
        ADDR_CONFIG: s_next.prdata[23:0] = s_reg.cfg;
        ADDR_CMDSTATE: s_next.prdata[31:0] = {s_reg.mode, s_reg.readByte,
                                              s_reg.addr};
        default: s_next.pslverr = 1'b1;
      endcase
      if (paddr[31:8] != 24'h0) begin
        s_next.pslverr = 1'b1;
        s_next.prdata = 32'h0;
      end
    end
    if (psel && penable && s_reg.pready && pwrite &&
        !s_reg.pslverr && apbAddr == ADDR_CTRL) begin
      s_next.linkEnable = pwdata[0];
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.tap <= TAP_RESET;
      s_reg.ir <= IR_BYPASS;
      s_reg.tdoOeN <= 1'b1;
      s_reg.linkEnable <= 1'b1;
      s_reg.cfg.fuseLo <= fuse_lo_t'(FUSE_LO_RST);
      s_reg.cfg.fuseHi <= fuse_hi_t'(FUSE_HI_RST);
      s_reg.cfg.lock <= lock_t'(LOCK_RST);
    end else begin
      s_reg <= s_next;
    end
  end

  assign tdo = s_reg.tdo;
  assign tdoOeN = s_reg.tdoOeN;
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign coreHold = s_reg.coreHold;
  assign progEnabled = s_reg.progEn;
  assign configBits = s_reg.cfg;
  assign bufWrite = s_reg.bufW;
  assign flashRead = s_reg.rd;
  assign eraseStrobe = s_reg.eraseStrobe;
  assign pageWrite = s_reg.pageWrite;
  assign pageAddr = s_reg.pageAddr;

endmodule : scan_port_flash_programmer

/* scan_prog_sva.sv */
// assertion checker for the scan-port flash programmer ports
`timescale 1ns/1ns
module scan_prog_sva import scan_prog_pkg::*; #(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PAGE_WRITE_CNT = PAGE_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic progEnabled,
  input wire buf_wr_t bufWrite,
  input wire flash_rd_t flashRead,
  input wire logic eraseStrobe,
  input wire logic pageWrite
);
  // ****************************************************************
  // busy window, with two cycles of slack at its end
  // ****************************************************************
  int busyCnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      busyCnt <= 0;
    end else if (eraseStrobe) begin
      busyCnt <= ERASE_CNT - 2;
    end else if (pageWrite) begin
      busyCnt <= PAGE_WRITE_CNT - 2;
    end else if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_with_ready: assert property ($changed(pslverr) |-> pready)
    else $error("pslverr changed outside an answer");
  chk_erase_pulse: assert property (eraseStrobe |=> !eraseStrobe)
    else $error("erase strobe longer than one cycle");
  chk_page_pulse: assert property (pageWrite |=> !pageWrite)
    else $error("page write strobe longer than one cycle");
  chk_busy_refuse: assert property (
    busyCnt != 0 |-> !eraseStrobe && !pageWrite)
    else $error("new erase or page write accepted while busy");
  chk_cmd_locked: assert property (
    eraseStrobe || pageWrite || bufWrite.write |-> progEnabled)
    else $error("programming action while programming is locked");
  chk_byte_spacing: assert property (
    bufWrite.write |=> !bufWrite.write [*8])
    else $error("buffer writes closer than one byte of shifting");
  chk_read_spacing: assert property (
    flashRead.req |=> !flashRead.req [*8])
    else $error("flash reads closer than one byte of shifting");
  chk_byte_copy: assert property (
    bufWrite.write && bufWrite.byteEn != 2'b11
      |-> bufWrite.data[15:8] == bufWrite.data[7:0])
    else $error("byte write data not copied to both halves");
endmodule : scan_prog_sva

bind scan_port_flash_programmer scan_prog_sva #(
  .ERASE_CNT(ERASE_CNT),
  .PAGE_WRITE_CNT(PAGE_WRITE_CNT)
) sva_inst (.clk, .rst, .psel, .penable, .pready, .pslverr, .progEnabled,
  .bufWrite, .flashRead, .eraseStrobe, .pageWrite);

/* scan_programmer.sv */
// boundary-scan programmer model driving the test port pins
`timescale 1ns/1ns
module scan_programmer import scan_prog_pkg::*; (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic [1031:0] shOut;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ****************************************************************
  // one test clock period of eight system clocks, tdo taken at rise
  // ****************************************************************
  task automatic step(input logic m, input logic dv, output logic o);
    @(posedge clk);
    tms <= m;
    tdi <= dv;
    repeat (3) @(posedge clk);
    o = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask : step
  // idle to shift, n bits lsb first, then update and back to idle
  task automatic scan(input logic isIr, input int n, input logic [1031:0] dv);
    logic o;
    step(1'b1, 1'b0, o);
    if (isIr) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, dv[i], o);
      shOut[i] = o;
    end
    step(1'b1, ~dv[n-1], o);
    step(1'b0, ~dv[n-1], o);
    // let the strobe of the last update be seen before the caller looks
    @(posedge clk);
  endtask : scan
  task automatic cmd(input logic [6:0] c, input logic [7:0] v);
    scan(1'b0, 15, {1017'h0, c, v});
  endtask : cmd
  task automatic tapReset;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : tapReset
  task automatic enterProg(input logic [15:0] key);
    scan(1'b1, 4, {1028'h0, IR_CORE_HOLD});
    scan(1'b0, 1, {1031'h0, 1'b1});
    scan(1'b1, 4, {1028'h0, IR_UNLOCK});
    scan(1'b0, 16, {1016'h0, key});
    scan(1'b1, 4, {1028'h0, IR_CMD});
  endtask : enterProg
  task automatic leaveProg;
    cmd(CMD_MODE, MODE_NOP);
    scan(1'b1, 4, {1028'h0, IR_UNLOCK});
    scan(1'b0, 16, 1032'h0);
    scan(1'b1, 4, {1028'h0, IR_CORE_HOLD});
    scan(1'b0, 1, 1032'h0);
  endtask : leaveProg
  task automatic leaveHeld;
    cmd(CMD_MODE, MODE_NOP);
    repeat (2) begin
      scan(1'b1, 4, {1028'h0, IR_UNLOCK});
      scan(1'b0, 16, 1032'h0);
    end
  endtask : leaveHeld
endmodule : scan_programmer

/* testbench.sv */
// self-checking testbench for the scan-port flash programmer
`timescale 1ns/1ns
module testbench import scan_prog_pkg::*;;
  logic clk, rst, tck, tms, tdi, tdo, tdoOeN, tdoPin;
  logic psel, penable, pwrite, pready, pslverr, coreHold, progEnabled;
  logic eraseStrobe, pageWrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] flashRdData, pageAddr, lastPage;
  config_t cfgOut;
  buf_wr_t bufWrite;
  flash_rd_t flashRead;
  logic [15:0] page [64];
  logic [1031:0] d;
  logic err;
  int fails, checkCount, eraseSeen, nWrites;

  scan_port_flash_programmer #(.ERASE_CNT(400), .PAGE_WRITE_CNT(400)) DUT (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOeN(tdoOeN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreHold(coreHold), .progEnabled(progEnabled),
    .configBits(cfgOut), .bufWrite(bufWrite), .flashRead(flashRead),
    .flashRdData(flashRdData), .eraseStrobe(eraseStrobe),
    .pageWrite(pageWrite), .pageAddr(pageAddr));
  // pulled-up pin while the device does not drive it
  assign tdoPin = tdoOeN ? 1'b1 : tdo;
  scan_programmer prog (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdoPin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************************************
  // flash model and strobe monitor
  // ****************************************************************
  always @(posedge clk) begin
    flashRdData <= flashRead.addr[7:0] ^ 8'h3c;
    if (eraseStrobe === 1'b1) eraseSeen++;
    if (pageWrite === 1'b1) lastPage = pageAddr;
    if (bufWrite.write === 1'b1) begin
      nWrites++;
      if (bufWrite.byteEn[0])
        page[bufWrite.wordIdx][7:0] = bufWrite.data[7:0];
      if (bufWrite.byteEn[1])
        page[bufWrite.wordIdx][15:8] = bufWrite.data[15:8];
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask : apb
  task automatic poll(input logic [6:0] c, input logic [7:0] v);
    logic done;
    done = 1'b0;
    for (int i = 0; i < 8 && done !== 1'b1; i++) begin
      prog.cmd(c, v);
      done = prog.shOut[DONE_BIT];
    end
    chk("done flag", 1, done);
  endtask : poll

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("tdo enable idle", 1, tdoOeN);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl reset", 1, rd);
    apb(0, ADDR_CONFIG, 0);
    chk("config reset", 32'hffffff, rd);
    apb(0, 32'h10, 0);
    chk("unmapped error", 1, err);
    apb(1, ADDR_CTRL, 0);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl written", 0, rd);
    apb(1, ADDR_CTRL, 1);
    prog.tapReset();
    prog.enterProg(16'ha371);
    chk("wrong key", 0, progEnabled);
    chk("core hold", 1, coreHold);
    prog.cmd(CMD_MODE, MODE_ERASE);
    prog.cmd(CMD_STROBE_A, MODE_ERASE);
    chk("locked erase", 0, eraseSeen);
    prog.enterProg(UNLOCK_KEY);
    chk("key accepted", 1, progEnabled);
    apb(0, ADDR_STATUS, 0);
    chk("status", 3, rd);
    prog.cmd(CMD_MODE, MODE_ERASE);
    prog.cmd(CMD_STROBE_A, MODE_ERASE);
    chk("erase started", 1, eraseSeen);
    poll(7'h33, MODE_ERASE);
    prog.cmd(CMD_MODE, MODE_FUSE_WR);
    prog.cmd(CMD_DATA_LO, 8'h5a);
    prog.cmd(CMD_STROBE_A, 8'h00);
    prog.cmd(CMD_DATA_LO, 8'ha5);
    prog.cmd(CMD_STROBE_B, 8'h00);
    prog.cmd(CMD_MODE, MODE_LOCK_WR);
    prog.cmd(CMD_DATA_LO, 8'hfc);
    prog.cmd(CMD_STROBE_A, 8'h00);
    prog.cmd(CMD_DATA_LO, 8'hf3);
    prog.cmd(CMD_STROBE_A, 8'h00);
    apb(0, ADDR_CONFIG, 0);
    chk("fuses and locks", 32'h5aa5f0, rd);
    prog.cmd(CMD_MODE, MODE_FLASH_WR);
    prog.cmd(CMD_ADDR_HI, 8'h00);
    prog.cmd(CMD_ADDR_LO, 8'h05);
    prog.cmd(CMD_DATA_LO, 8'h34);
    prog.cmd(CMD_DATA_HI, 8'h12);
    prog.cmd(CMD_LATCH, 8'h00);
    chk("latched word", 16'h1234, page[5]);
    prog.cmd(CMD_ADDR_LO, 8'h40);
    for (int k = 0; k < 64; k++) d[16*k +: 16] = {8'(k), 8'(~k)};
    prog.scan(1'b1, 4, {1028'h0, IR_PAGE_FILL});
    prog.scan(1'b0, 1024, d);
    prog.scan(1'b1, 4, {1028'h0, IR_CMD});
    chk("buffer writes", 129, nWrites);
    for (int k = 0; k < 64; k++) begin
      chk("page word", {8'(k), 8'(~k)}, page[k]);
    end
    prog.cmd(CMD_STROBE_B, 8'h00);
    chk("page number", 1, lastPage);
    poll(7'h37, 8'h00);
    prog.cmd(CMD_MODE, MODE_FLASH_RD);
    prog.cmd(CMD_ADDR_LO, 8'h40);
    prog.scan(1'b1, 4, {1028'h0, IR_PAGE_DUMP});
    prog.scan(1'b0, 1032, 1032'h0);
    prog.scan(1'b1, 4, {1028'h0, IR_CMD});
    for (int k = 0; k < 128; k++) begin
      chk("dump byte", 8'(8'h80 + k) ^ 8'h3c, prog.shOut[8*k+8 +: 8]);
    end
    prog.leaveProg();
    chk("unlock cleared", 0, progEnabled);
    chk("core released", 0, coreHold);
    prog.enterProg(UNLOCK_KEY);
    prog.leaveHeld();
    repeat (40) @(posedge clk);
    chk("unlock cleared twice", 0, progEnabled);
    chk("core still held", 1, coreHold);
    close_out();
  end
endmodule : testbench
